// *** hw/epc_ctrl.sv ***
`timescale 1ns/1ps
module epc_ctrl
  import epc_pkg::*;
#(
  parameter int RC_SETTLE_CYC = EPC_RC_SETTLE_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  epc_bus_req_t    bus_i,
  output logic      [7:0] rdata_o,
  output logic            rdata_valid_o,
  output logic            pump_on_o,
  output logic            prog_power_o,
  output logic            array_clk_sel_o,
  output logic            array_clk_ready_o,
  output logic            bus_latched_o,
  output logic            read_blocked_o
);

  // Programming control register and its fields.

  logic [7:0]  eeprom_program_control;
  logic [7:0]  next_ctl;
  logic        write_seen;
  logic        next_write_seen;
  logic [7:0]  tgt_addr;
  logic [7:0]  tgt_data;
  logic [7:0]  arr_rd_data;
  logic [7:0]  next_rdata;
  logic [15:0] settle_cnt;

  wire pump_enable        = eeprom_program_control[EPC_BIT_PUMP];
  wire erase_select_high  = eeprom_program_control[EPC_BIT_ERASE_HI];
  wire erase_select_low   = eeprom_program_control[EPC_BIT_ERASE_LO];
  wire latch_bit          = eeprom_program_control[EPC_BIT_LATCH];
  wire array_clock_select = eeprom_program_control[EPC_BIT_CLK_SEL];
  wire programming_power  = eeprom_program_control[EPC_BIT_POWER];

  epc_op_t op_sel;

  // The operation code is simply the two select bits side by side.
  assign op_sel = epc_op_t'({erase_select_high, erase_select_low}); // [R7]

  // Address decode.

  // Only the control byte and the array page answer the bus.
  wire ctl_hit = (bus_i.addr == EPC_CTL_ADDR); // [R3]
  wire arr_hit = (bus_i.addr[15:8] == EPC_ARRAY_PAGE); // [R1]

  wire ctl_wr = bus_i.wr & ctl_hit;
  wire ctl_rd = bus_i.rd & ctl_hit;
  wire arr_wr = bus_i.wr & arr_hit;
  wire arr_rd = bus_i.rd & arr_hit;

  // Array reads are blocked once a latched write has captured a target.
  wire arr_blocked = latch_bit & write_seen; // [R12]

  // Next value of the control register.

  // The power bit may be cleared at any time, but it can only be set
  // when the latch bit is already one before this write.  A single
  // write that sets both latch and power therefore leaves power off,
  // which stops a stray byte from pulsing an unprepared array.
  wire power_set_ok = latch_bit; // [R16]
  wire next_power   = bus_i.wdata[EPC_BIT_POWER] & power_set_ok; // [R16]

  // Bits 7 and 5 are not stored; the mask keeps them zero.
  wire [7:0] wr_fields = bus_i.wdata & EPC_CTL_RW_MASK; // [R23]

  always_comb begin
    next_ctl = eeprom_program_control;
    if (ctl_wr) begin
      next_ctl = wr_fields; // [R21]
      next_ctl[EPC_BIT_POWER] = next_power;
    end
  end

  // Register update.  Reset brings every bit to zero.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      eeprom_program_control <= EPC_CTL_RESET; // [R21]
    end else begin
      eeprom_program_control <= next_ctl;
    end
  end

  // Address and data latches for the array.

  // A write into the array page while latched only captures the target;
  // with the latch clear the array is read-only and the write is lost.
  wire capture = arr_wr & latch_bit; // [R11]

  // The capture flag clears on the cycle after the latch is released,
  // so normal reads return once the buses are handed back.
  always_comb begin
    next_write_seen = write_seen;
    if (!latch_bit) begin
      next_write_seen = 1'b0;
    end
    if (capture) begin
      next_write_seen = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      write_seen <= 1'b0;
    end else begin
      write_seen <= next_write_seen;
    end
  end

  // Target address and data are plain data registers.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tgt_addr <= 8'h00;
      tgt_data <= 8'h00;
    end else if (capture) begin
      tgt_addr <= bus_i.addr[7:0]; // [R11]
      tgt_data <= bus_i.wdata; // [R11]
    end
  end

  // Power and clock controls.

  // The pump runs for either bit: the pump enable pre-charges it and the
  // programming power bit also turns it on while the pulse lasts.
  assign pump_on_o = pump_enable | programming_power; // [R4] [R15]

  // Array voltage follows only the power bit, never the pump enable,
  // so the pulse width is exactly the time software holds the bit.
  assign prog_power_o = programming_power; // [R6] [R15]

  // One selects the RC oscillator for the array, zero the CPU clock.
  assign array_clk_sel_o = array_clock_select; // [R13]
  assign bus_latched_o   = latch_bit;
  assign read_blocked_o  = arr_blocked;

  // RC oscillator settling indication.

  // The count restarts whenever the RC source is deselected.  It is
  // only a status hint; nothing in the block waits on it, because the
  // waiting is software's duty.
  wire settle_done = (settle_cnt >= 16'(RC_SETTLE_CYC)); // [R24]

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      settle_cnt <= 16'h0000;
    end else if (!array_clock_select) begin
      settle_cnt <= 16'h0000;
    end else if (!settle_done) begin
      settle_cnt <= settle_cnt + 16'h0001;
    end
  end

  // The CPU clock is always ready; the RC source after its settle time.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      array_clk_ready_o <= 1'b1;
    end else begin
      array_clk_ready_o <= !array_clock_select | settle_done;
    end
  end

  // Array storage.

  epc_array #(
    .DEPTH (EPC_ARRAY_SIZE)
  ) u_array (
    .ref_clk_i  (ref_clk_i),
    .power_i    (programming_power), // [R6]
    .op_i       (op_sel),
    .tgt_addr_i (tgt_addr),
    .tgt_data_i (tgt_data),
    .rd_addr_i  (bus_i.addr[7:0]),
    .rd_data_o  (arr_rd_data)
  );

  // Read data path.

  // Read data selection.  A blocked array read and an unmapped read
  // both return the same neutral value, so the valid flag is what
  // tells software whether the byte was real.
  wire arr_rd_ok = arr_rd & !arr_blocked; // [R12]

  always_comb begin
    next_rdata = EPC_UNMAPPED_VAL;
    if (ctl_rd) begin
      next_rdata = eeprom_program_control; // [R16] [R23]
    end else if (arr_rd_ok) begin
      next_rdata = arr_rd_data;
    end
  end

  // Read answer arrives one cycle after the request and holds one cycle.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o       <= 8'h00;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_o       <= next_rdata;
      rdata_valid_o <= ctl_rd | arr_rd_ok;
    end
  end

endmodule : epc_ctrl

// *** shared/epc_pkg.sv ***
// Overview of operation
// [R1] Array of 256 bytes at 0x0400 to 0x04FF.
// [R2] Erased byte reads ones; programming clears bits only.
// [R3] All operations steered by control register 0x001C.
// [R4] Pump enable bit switches the charge pump.
// [R5] Software sets pump with latch, idles pump off.
// [R6] No array voltage until programming power set.
// [R7] Select bits: program, byte, block, bulk erase.
// [R8] Byte erase touches only the latched byte.
// [R9] Block erase clears the latched 64-byte block.
// [R10] Bulk erase clears all 256 bytes.
// [R11] Latch bit captures array write address and data.
// [R12] Array reads blocked after latched write.
// [R13] Clock select: one RC oscillator, zero CPU.
// [R14] Software uses RC below 1.5MHz, waits settle.
// [R15] Programming power drives pump and array power.
// [R16] Power bit readable; set needs latch already one.
// [R17] Program: latch, pump, code 00, write, pulse.
// [R18] Erase: latch, pump, erase code, write, pulse.
// [R19] End: drop power, wait fall, drop latch, pump.
// [R20] Software zeroes control bits after each sequence.
// [R21] Reset clears control register; fields read/write.
// [R22] Software writes zeros into reserved bits.
// [R23] Bits 7 and 5 read zero, ignore writes.
// [R24] Sequence durations are configurable constants.
package epc_pkg;

  // Memory map of the block.
  localparam logic [15:0] EPC_CTL_ADDR   = 16'h001C;
  localparam logic [7:0]  EPC_ARRAY_PAGE = 8'h04; // Upper address byte of the array.
  localparam int          EPC_ARRAY_SIZE = 256;
  localparam int          EPC_BLOCK_SIZE = 64;

  // Control register fields.
  localparam int EPC_BIT_POWER     = 0;
  localparam int EPC_BIT_CLK_SEL   = 1;
  localparam int EPC_BIT_LATCH     = 2;
  localparam int EPC_BIT_ERASE_LO  = 3;
  localparam int EPC_BIT_ERASE_HI  = 4;
  localparam int EPC_BIT_PUMP      = 6;
  localparam logic [7:0] EPC_CTL_RESET    = 8'h00;
  localparam logic [7:0] EPC_CTL_RW_MASK  = 8'h5E;
  localparam logic [7:0] EPC_ERASED_BYTE  = 8'hFF;
  localparam logic [7:0] EPC_UNMAPPED_VAL = 8'h00;

  // Durations in nanoseconds, the settle count in clock cycles; software times every pulse itself.
  localparam int EPC_CLK_PERIOD_NS     = 20;
  localparam int EPC_RC_SETTLE_NS      = 10000;
  localparam int EPC_PROGRAM_PULSE_NS  = 10000000;
  localparam int EPC_BYTE_ERASE_NS     = 10000000;
  localparam int EPC_BLOCK_ERASE_NS    = 10000000;
  localparam int EPC_BULK_ERASE_NS     = 10000000;
  localparam int EPC_VOLTAGE_FALL_NS   = 10000;
  localparam int EPC_RC_SETTLE_CYC =
    (EPC_RC_SETTLE_NS + EPC_CLK_PERIOD_NS - 1) / EPC_CLK_PERIOD_NS;

  // Operation chosen by the two erase select bits.
  typedef enum logic [1:0] {
    EPC_OP_PROGRAM     = 2'h0,
    EPC_OP_BYTE_ERASE  = 2'h1,
    EPC_OP_BLOCK_ERASE = 2'h2,
    EPC_OP_BULK_ERASE  = 2'h3
  } epc_op_t;

  // CPU bus request, one cycle per access.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } epc_bus_req_t;

endpackage : epc_pkg

// *** hw/epc_array.sv ***
`timescale 1ns/1ps
module epc_array
  import epc_pkg::*;
#(
  parameter int DEPTH = EPC_ARRAY_SIZE
) (
  input  wire logic       ref_clk_i,
  input  wire logic       power_i,
  input  epc_op_t         op_i,
  input  wire logic [7:0] tgt_addr_i,
  input  wire logic [7:0] tgt_data_i,
  input  wire logic [7:0] rd_addr_i,
  output logic      [7:0] rd_data_o
);

  logic [7:0] cells [DEPTH];

  // Each cell decides alone whether the applied power reaches it.
  // Holding power longer repeats an idempotent action, so the pulse
  // width is fully in software's hands.
  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    localparam logic [7:0] IDX = 8'(i);
    wire hit_byte  = (IDX == tgt_addr_i);
    wire hit_block = (IDX[7:6] == tgt_addr_i[7:6]); // [R9]
    wire erase_me  = (op_i == EPC_OP_BULK_ERASE) // [R10]
                   | ((op_i == EPC_OP_BLOCK_ERASE) & hit_block)
                   | ((op_i == EPC_OP_BYTE_ERASE) & hit_byte); // [R8]
    wire prog_me   = (op_i == EPC_OP_PROGRAM) & hit_byte;

    // Cells are nonvolatile, so reset leaves them alone.
    always_ff @(posedge ref_clk_i) begin
      if (power_i && erase_me) begin
        cells[i] <= EPC_ERASED_BYTE; // [R2]
      end else if (power_i && prog_me) begin
        cells[i] <= cells[i] & tgt_data_i; // [R2]
      end
    end
  end

  assign rd_data_o = cells[rd_addr_i];

endmodule : epc_array

// *** bench/epc_monitor.sv ***
`timescale 1ns/1ps
module epc_monitor
  import epc_pkg::*;
#(
  parameter int RC_SETTLE_CYC = EPC_RC_SETTLE_CYC
) (
  input wire logic       ref_clk_i,
  input wire logic       srst_i,
  input epc_bus_req_t    bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rdata_valid_o,
  input wire logic       pump_on_o,
  input wire logic       prog_power_o,
  input wire logic       array_clk_sel_o,
  input wire logic       array_clk_ready_o,
  input wire logic       bus_latched_o,
  input wire logic       read_blocked_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // Access decode, kept apart so each property reads as one cause.
  wire         ctl_wr  = bus_i.wr && bus_i.addr == EPC_CTL_ADDR;
  wire         ctl_rd  = bus_i.rd && bus_i.addr == EPC_CTL_ADDR;
  wire         in_arr  = bus_i.addr[15:8] == EPC_ARRAY_PAGE;
  wire         bad_rd  = bus_i.rd && !in_arr && bus_i.addr != EPC_CTL_ADDR;
  wire         pwr_rq  = ctl_wr && bus_i.wdata[EPC_BIT_POWER];
  wire         pump_rq = bus_i.wdata[EPC_BIT_PUMP];
  wire   [1:0] lc_rq   = {bus_i.wdata[EPC_BIT_LATCH], bus_i.wdata[EPC_BIT_CLK_SEL]};
  wire         lat_wr  = bus_i.wr && in_arr && bus_latched_o;
  logic [15:0] sel_cnt;
  // Cycles since the RC source was chosen; it saturates so it never wraps back.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || !array_clk_sel_o) begin
      sel_cnt <= 16'h0000;
    end else if (sel_cnt != 16'hFFFF) begin
      sel_cnt <= sel_cnt + 16'h0001;
    end
  end
  // The first counted cycle still shows the old ready flag, so it is skipped.
  wire rc_early = array_clk_sel_o && sel_cnt != 16'h0000 && sel_cnt <= 16'(RC_SETTLE_CYC);
  ctl_read_a: assert property (ctl_rd |=> rdata_valid_o && !rdata_o[7] && !rdata_o[5])
    else $error("control read wrong");
  unmapped_read_a: assert property (bad_rd |=> !rdata_valid_o && rdata_o == 8'h00)
    else $error("unmapped read answered");
  power_gate_a: assert property (pwr_rq && !bus_latched_o |=> !prog_power_o)
    else $error("power set without latch");
  power_set_a: assert property (pwr_rq && bus_latched_o |=> prog_power_o)
    else $error("power not applied");
  pump_follow_a: assert property (ctl_wr |=> pump_on_o == ($past(pump_rq) || prog_power_o))
    else $error("pump state wrong");
  fields_a: assert property (ctl_wr |=> {bus_latched_o, array_clk_sel_o} == $past(lc_rq))
    else $error("latch or clock field wrong");
  read_block_a: assert property (read_blocked_o && bus_i.rd && in_arr |=> !rdata_valid_o)
    else $error("blocked read answered");
  block_cause_a: assert property ($rose(read_blocked_o) |-> $past(lat_wr))
    else $error("block without latched write");
  rc_settle_a: assert property (rc_early |-> !array_clk_ready_o)
    else $error("rc ready before settle time");
  cover property (prog_power_o && read_blocked_o);
  cover property (ctl_wr && bus_i.wdata[4:3] == 2'h3);
  cover property (array_clk_sel_o && array_clk_ready_o);
endmodule : epc_monitor

// *** bench/eeprom_program_erase_control_tb.sv ***
`timescale 1ns/1ps
module eeprom_program_erase_control_tb;
  import epc_pkg::*;
  logic         ref_clk_i = 1'b0;
  logic         srst_i = 1'b1;
  epc_bus_req_t bus_i = '0;
  logic [7:0]   rdata_o;
  logic         rvld, pump, pwr, csel, crdy, latched, blocked;
  int           mismatches = 0;
  int           check_count = 0;
  int           n;
  logic [7:0]   mem [256];
  logic [31:0]  lfsr = 32'hA558534E;
  // Free-running 50 MHz clock.
  always #10 ref_clk_i = ~ref_clk_i;
  epc_ctrl #(.RC_SETTLE_CYC(4)) i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .rdata_valid_o(rvld), .pump_on_o(pump), .prog_power_o(pwr),
    .array_clk_sel_o(csel), .array_clk_ready_o(crdy), .bus_latched_o(latched),
    .read_blocked_o(blocked));
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  // One bus access; released on the edge that takes it, result settled 1 ns later.
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk_i);
    bus_i <= '0;
    #1;
  endtask : acc
  task automatic rd(input logic [15:0] a, input bit ev, input logic [7:0] ed);
    acc(a, 8'h00, 1'b0);
    chk(rvld === ev && rdata_o === ed, "read mismatch");
  endtask : rd
  // Full software sequence; the model array is updated once the pulse ends.
  task automatic seq(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] c;
    c = 8'h44 | {3'h0, op, 3'h0};
    acc(EPC_CTL_ADDR, c | 8'h01, 1'b1);
    chk(pwr === 1'b0 && latched === 1'b1 && pump === 1'b1, "power gate");
    acc({EPC_ARRAY_PAGE, a}, d, 1'b1);
    chk(blocked === 1'b1, "no capture");
    rd({EPC_ARRAY_PAGE, a}, 1'b0, 8'h00);
    acc(EPC_CTL_ADDR, c | 8'h01, 1'b1);
    chk(pwr === 1'b1 && pump === 1'b1, "no power");
    repeat (3) @(posedge ref_clk_i);
    acc(EPC_CTL_ADDR, c, 1'b1);
    chk(pwr === 1'b0, "power stuck");
    rd(EPC_CTL_ADDR, 1'b1, c);
    acc(EPC_CTL_ADDR, 8'h00, 1'b1);
    chk(blocked === 1'b0 && pump === 1'b0, "not released");
    for (int i = 0; i < 256; i++) begin
      if (op == 2'h3 || (op == 2'h2 && i[7:6] == a[7:6]) || (op == 2'h1 && i == a)) begin
        mem[i] = EPC_ERASED_BYTE;
      end
    end
    if (op == 2'h0) begin
      mem[a] &= d;
    end
  endtask : seq
  task automatic verify();
    for (int i = 0; i < 256; i++) begin
      rd({EPC_ARRAY_PAGE, 8'(i)}, 1'b1, mem[i]);
    end
  endtask : verify
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // Main sequence: reset, register fields, clock select, then every operation code.
  initial begin
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(EPC_CTL_ADDR, 1'b1, EPC_CTL_RESET);
    chk(crdy === 1'b1 && pump === 1'b0 && pwr === 1'b0, "reset outputs");
    // Reserved bits stay zero in every write; the power bit is refused without the latch.
    acc(EPC_CTL_ADDR, 8'h5F, 1'b1);
    rd(EPC_CTL_ADDR, 1'b1, 8'h5E);
    chk(pump === 1'b1 && pwr === 1'b0 && csel === 1'b1, "field write");
    chk(crdy === 1'b0, "rc ready early");
    for (n = 0; n < 50 && crdy !== 1'b1; n++) begin
      @(posedge ref_clk_i);
    end
    chk(crdy === 1'b1, "rc never ready");
    if (crdy !== 1'b1) begin
      complete_run();
    end
    acc(EPC_CTL_ADDR, 8'h00, 1'b1);
    seq(2'h3, rnd(), rnd());
    acc({EPC_ARRAY_PAGE, 8'h10}, 8'h00, 1'b1);
    chk(blocked === 1'b0, "write without latch");
    verify();
    rd(16'h0500, 1'b0, 8'h00);
    rd(16'h03FF, 1'b0, 8'h00);
    for (int k = 0; k < 8; k++) begin
      seq(k[1:0], rnd(), rnd());
      verify();
    end
    complete_run();
  end
endmodule : eeprom_program_erase_control_tb
bind epc_ctrl epc_monitor #(.RC_SETTLE_CYC(RC_SETTLE_CYC)) i_mon (.ref_clk_i(ref_clk_i),
  .srst_i(srst_i), .bus_i(bus_i), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
  .pump_on_o(pump_on_o), .prog_power_o(prog_power_o), .array_clk_sel_o(array_clk_sel_o),
  .array_clk_ready_o(array_clk_ready_o), .bus_latched_o(bus_latched_o),
  .read_blocked_o(read_blocked_o));
